// File: sics_pkg.sv
// Purpose: Shared constants and types for the sensor serial command target port
// Assumes: Two-wire bus, 8-bit bytes, 24-bit conversion values
// Notes:   Result values and register data come from core logic on core_clk
package sics_pkg;
   localparam logic [5:0] ADDR_FIXED       = 6'h3B;
   localparam logic [7:0] CMD_SOFT_RESET   = 8'h06;
   localparam logic [7:0] CMD_READ_TEMP_PRESSURE = 8'h10;
   localparam logic [7:0] CMD_READ_TEMP_ALTITUDE = 8'h11;
   localparam logic [7:0] CMD_READ_PRESSURE = 8'h30;
   localparam logic [7:0] CMD_READ_ALTITUDE = 8'h31;
   localparam logic [7:0] CMD_READ_TEMP    = 8'h32;
   localparam logic [1:0] PFX_REG_READ     = 2'h2;
   localparam logic [1:0] PFX_REG_WRITE    = 2'h3;
   localparam logic [3:0] BIT_LAST         = 4'h7;
   localparam logic [3:0] BIT_ACK          = 4'h8;
   localparam logic [2:0] LEN_NONE         = 3'h0;
   localparam logic [2:0] LEN_REG          = 3'h1;
   localparam logic [2:0] LEN_SINGLE       = 3'h3;
   localparam logic [2:0] LEN_DOUBLE       = 3'h6;
   localparam int         VAL_W            = 24;
   localparam int         SNAP_W           = 2 * VAL_W;

   typedef struct packed {
      logic [VAL_W-1:0] temp;
      logic [VAL_W-1:0] press;
      logic [VAL_W-1:0] alt;
   } sics_result_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] data;
   } sics_reg_wr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_CMD  = 3'h3,
      ST_DATA = 3'h2,
      ST_READ = 3'h6
   } sics_state_t;
endpackage

// File: sics_i2c_slave.sv
// Purpose: Two-wire command target port of a pressure and temperature sensor
// Assumes: scl_in clocks the link logic; sda_in is the sensed data wire level
// Notes:   Open-drain data: sda_out is always low, sda_oe pulls the wire
// Operation
// R1: Every byte shifts most significant bit first in both directions.
// R2: Address select low answers 0xEE/0xEF, high answers 0xEC/0xED.
// R3: Top six address bits fixed, A1 is inverted select, last bit is direction.
// R4: Host sends start, write address, one command byte, stop.
// R5: Soft reset byte is acknowledged first, reset follows afterwards.
// R6: Register write is address, write-command byte, one data byte, stop.
// R7: Register read is a command frame with prefix 10 and 6-bit address.
// R8: Following read frame returns the previously addressed register content.
// R9: Read frame after a result command returns three or six bytes.
// R10: Combined reads give temperature then second value; single reads one value.
// R11: Register write command carries prefix 11 and a 6-bit address.
// R12: Command 0x06 resets device storage and reruns power-up after its acknowledge.
// R13: Acknowledge matching address and received bytes; stay released otherwise.
// R14: Host acknowledges all read bytes except the last, then stops.
`timescale 1ns/1ps
module sics_i2c_slave (
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe,
   input  wire logic                address_select_pin,
   input  wire sics_pkg::sics_result_t results,
   input  wire logic [7:0]          reg_rdata,
   output logic [5:0]               reg_addr,
   output logic                     cmd_valid,
   output logic [7:0]               cmd_code,
   output logic                     wr_valid,
   output sics_pkg::sics_reg_wr_t   wr,
   output logic                     soft_reset
);
   import sics_pkg::*;

   // Start detection on the falling data edge while the clock is high
   logic start_tog_r;
   logic start_tog_nxt;

   always_comb begin
      start_tog_nxt = scl_in ? ~start_tog_r : start_tog_r;
   end

   always_ff @(negedge sda_in or negedge reset_n) begin
      if (!reset_n) begin
         start_tog_r <= 1'b0;
      end else begin
         start_tog_r <= start_tog_nxt;
      end
   end

   // Link state on the rising bus clock
   sics_state_t       st_r, st_nxt, after_r, after_nxt;
   logic [3:0]        bit_r, bit_nxt;
   logic [7:0]        sh_r, sh_nxt, cmd_r, cmd_nxt;
   logic [7:0]        byte_in;
   logic              seen_r, seen_nxt, ack_r, ack_nxt;
   logic [2:0]        len_r, len_nxt, idx_r, idx_nxt;
   sics_reg_wr_t      wrl_r, wrl_nxt;
   logic              cmd_tog_r, cmd_tog_nxt, wr_tog_r, wr_tog_nxt;
   logic              sel_meta_r, sel_r;
   logic [SNAP_W-1:0] snap_r;

   function automatic logic [2:0] read_len(input logic [7:0] c);
      if (c[7:6] == PFX_REG_READ) begin
         read_len = LEN_REG;
      end else if (c == CMD_READ_TEMP_PRESSURE || c == CMD_READ_TEMP_ALTITUDE) begin
         read_len = LEN_DOUBLE;
      end else if (c == CMD_READ_PRESSURE || c == CMD_READ_ALTITUDE || c == CMD_READ_TEMP) begin
         read_len = LEN_SINGLE;
      end else begin
         read_len = LEN_NONE;
      end
   endfunction

   always_comb begin
      st_nxt      = st_r;
      after_nxt   = after_r;
      bit_nxt     = bit_r;
      sh_nxt      = sh_r;
      cmd_nxt     = cmd_r;
      seen_nxt    = seen_r;
      ack_nxt     = ack_r;
      len_nxt     = len_r;
      idx_nxt     = idx_r;
      wrl_nxt     = wrl_r;
      cmd_tog_nxt = cmd_tog_r;
      wr_tog_nxt  = wr_tog_r;
      byte_in     = {sh_r[6:0], sda_in}; // R1
      if (start_tog_r != seen_r) begin
         seen_nxt = start_tog_r;
         st_nxt   = ST_ADDR;
         sh_nxt   = byte_in;
         bit_nxt  = 4'h1;
         ack_nxt  = 1'b0;
      end else if (st_r != ST_IDLE) begin
         if (bit_r == BIT_ACK) begin
            bit_nxt = 4'h0;
            ack_nxt = 1'b0;
            if (st_r == ST_READ) begin
               if (sda_in) begin
                  st_nxt = ST_IDLE; // R14
               end else begin
                  idx_nxt = idx_r + 3'h1;
               end
            end else begin
               st_nxt = after_r;
               if (ack_r && st_r == ST_CMD) begin
                  cmd_tog_nxt = ~cmd_tog_r; // R5
               end
               if (ack_r && st_r == ST_DATA) begin
                  wr_tog_nxt = ~wr_tog_r;
               end
            end
         end else begin
            sh_nxt  = byte_in;
            bit_nxt = bit_r + 4'h1;
            if (bit_r == BIT_LAST) begin
               case (st_r)
                  ST_ADDR: begin
                     if (byte_in[7:1] == {ADDR_FIXED, ~sel_r}) begin // R2 R3
                        ack_nxt   = 1'b1; // R13
                        after_nxt = byte_in[0] ? ST_READ : ST_CMD; // R3
                        idx_nxt   = 3'h0;
                     end else begin
                        after_nxt = ST_IDLE; // R13
                     end
                  end
                  ST_CMD: begin
                     ack_nxt   = 1'b1; // R13
                     cmd_nxt   = byte_in;
                     len_nxt   = read_len(byte_in); // R7 R9
                     after_nxt = (byte_in[7:6] == PFX_REG_WRITE) ? ST_DATA : ST_IDLE; // R4 R6 R11
                  end
                  ST_DATA: begin
                     ack_nxt   = 1'b1; // R13
                     wrl_nxt   = '{addr: cmd_r[5:0], data: byte_in}; // R6 R11
                     after_nxt = ST_IDLE;
                  end
                  default: begin
                     after_nxt = after_r;
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge scl_in or negedge reset_n) begin
      if (!reset_n) begin
         st_r       <= ST_IDLE;
         after_r    <= ST_IDLE;
         bit_r      <= 4'h0;
         sh_r       <= 8'h00;
         cmd_r      <= 8'h00;
         seen_r     <= 1'b0;
         ack_r      <= 1'b0;
         len_r      <= LEN_NONE;
         idx_r      <= 3'h0;
         wrl_r      <= '0;
         cmd_tog_r  <= 1'b0;
         wr_tog_r   <= 1'b0;
         sel_meta_r <= 1'b0;
         sel_r      <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         after_r    <= after_nxt;
         bit_r      <= bit_nxt;
         sh_r       <= sh_nxt;
         cmd_r      <= cmd_nxt;
         seen_r     <= seen_nxt;
         ack_r      <= ack_nxt;
         len_r      <= len_nxt;
         idx_r      <= idx_nxt;
         wrl_r      <= wrl_nxt;
         cmd_tog_r  <= cmd_tog_nxt;
         wr_tog_r   <= wr_tog_nxt;
         sel_meta_r <= address_select_pin;
         sel_r      <= sel_meta_r;
      end
   end

   // Data drive on the falling bus clock
   logic              oe_r, oe_nxt;
   logic [SNAP_W-1:0] tx_word;
   logic [7:0]        tx_byte;

   always_comb begin
      tx_word = snap_r << {idx_r, 3'h0}; // R1 R10
      tx_byte = (idx_r < len_r) ? tx_word[SNAP_W-1 -: 8] : 8'h00; // R9
      oe_nxt  = 1'b0;
      if (st_r != ST_IDLE && bit_r == BIT_ACK) begin
         oe_nxt = ack_r; // R13
      end else if (st_r == ST_READ) begin
         oe_nxt = ~tx_byte[3'(BIT_LAST - bit_r)]; // R1 R8
      end
   end

   always_ff @(negedge scl_in or negedge reset_n) begin
      if (!reset_n) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= oe_nxt;
      end
   end

   assign sda_oe  = oe_r;
   assign sda_out = 1'b0;

   // Core side: event crossing, snapshot of reply data
   logic [2:0]        cmd_sync_r, cmd_sync_nxt, wr_sync_r, wr_sync_nxt;
   logic              cmd_ev, wr_ev, pend_r, pend_nxt;
   logic              cmd_valid_r, cmd_valid_nxt, wr_valid_r, wr_valid_nxt;
   logic              soft_reset_r, soft_reset_nxt;
   logic [7:0]        cmd_code_r, cmd_code_nxt;
   logic [5:0]        reg_addr_r, reg_addr_nxt;
   sics_reg_wr_t      wr_r, wr_nxt;
   logic [SNAP_W-1:0] snap_nxt;

   always_comb begin
      cmd_sync_nxt   = {cmd_sync_r[1:0], cmd_tog_r};
      wr_sync_nxt    = {wr_sync_r[1:0], wr_tog_r};
      cmd_ev         = cmd_sync_r[1] ^ cmd_sync_r[2];
      wr_ev          = wr_sync_r[1] ^ wr_sync_r[2];
      cmd_valid_nxt  = cmd_ev;
      wr_valid_nxt   = wr_ev;
      pend_nxt       = cmd_ev;
      cmd_code_nxt   = cmd_ev ? cmd_r : cmd_code_r;
      wr_nxt         = wr_ev ? wrl_r : wr_r;
      soft_reset_nxt = cmd_ev && (cmd_r == CMD_SOFT_RESET); // R5 R12
      reg_addr_nxt   = reg_addr_r;
      if (cmd_ev && cmd_r[7:6] == PFX_REG_READ) begin
         reg_addr_nxt = cmd_r[5:0]; // R7
      end
      snap_nxt = snap_r;
      if (soft_reset_r) begin
         snap_nxt = '0; // R12
      end else if (pend_r) begin
         case (cmd_code_r)
            CMD_READ_TEMP_PRESSURE: snap_nxt = {results.temp, results.press}; // R10
            CMD_READ_TEMP_ALTITUDE: snap_nxt = {results.temp, results.alt}; // R10
            CMD_READ_PRESSURE:      snap_nxt = {results.press, {VAL_W{1'b0}}};
            CMD_READ_ALTITUDE:      snap_nxt = {results.alt, {VAL_W{1'b0}}};
            CMD_READ_TEMP:          snap_nxt = {results.temp, {VAL_W{1'b0}}};
            default: begin
               if (cmd_code_r[7:6] == PFX_REG_READ) begin
                  snap_nxt = {reg_rdata, {(SNAP_W-8){1'b0}}}; // R8
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_sync_r   <= 3'h0;
         wr_sync_r    <= 3'h0;
         pend_r       <= 1'b0;
         cmd_valid_r  <= 1'b0;
         wr_valid_r   <= 1'b0;
         soft_reset_r <= 1'b0;
         cmd_code_r   <= 8'h00;
         reg_addr_r   <= 6'h00;
         wr_r         <= '0;
         snap_r       <= '0;
      end else begin
         cmd_sync_r   <= cmd_sync_nxt;
         wr_sync_r    <= wr_sync_nxt;
         pend_r       <= pend_nxt;
         cmd_valid_r  <= cmd_valid_nxt;
         wr_valid_r   <= wr_valid_nxt;
         soft_reset_r <= soft_reset_nxt;
         cmd_code_r   <= cmd_code_nxt;
         reg_addr_r   <= reg_addr_nxt;
         wr_r         <= wr_nxt;
         snap_r       <= snap_nxt;
      end
   end

   assign cmd_valid  = cmd_valid_r;
   assign cmd_code   = cmd_code_r;
   assign wr_valid   = wr_valid_r;
   assign wr         = wr_r;
   assign soft_reset = soft_reset_r;
   assign reg_addr   = reg_addr_r;
endmodule

// File: sics_placeholder_unused.sv
// Purpose: Reserved slot, holds no logic
// Assumes: Nothing
// Notes:   All target port logic lives in sics_i2c_slave.sv

// File: sics_i2c_slave_chk.sv
// Purpose: Assertions on the target port outputs
// Assumes: Bound into sics_i2c_slave
// Notes:   One link check on scl_in, the rest on core_clk
`timescale 1ns/1ps
module sics_i2c_slave_chk (
   input wire logic                   core_clk,
   input wire logic                   reset_n,
   input wire logic                   scl_in,
   input wire logic                   sda_oe,
   input wire logic [5:0]             reg_addr,
   input wire logic                   cmd_valid,
   input wire logic [7:0]             cmd_code,
   input wire logic                   wr_valid,
   input wire sics_pkg::sics_reg_wr_t wr,
   input wire logic                   soft_reset
);
   import sics_pkg::*;
   logic oe_rise_r;
   logic oe_rise_nxt;
   always_comb oe_rise_nxt = sda_oe;
   always_ff @(posedge scl_in or negedge reset_n) begin
      if (!reset_n)
         oe_rise_r <= 1'b0;
      else
         oe_rise_r <= oe_rise_nxt;
   end
   a_oe_held_high: assert property (@(negedge scl_in) disable iff (!reset_n)
      sda_oe == oe_rise_r) else $error("SDA drive changed while SCL high");
   a_cmd_one_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmd_valid |=> !cmd_valid) else $error("Command strobe longer than one cycle");
   a_code_held: assert property (@(posedge core_clk) disable iff (!reset_n)
      !cmd_valid |-> $stable(cmd_code)) else $error("Command code changed without strobe");
   a_reset_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
      soft_reset |-> cmd_valid && cmd_code == CMD_SOFT_RESET) else $error("Stray reset");
   a_reset_fires: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmd_valid && cmd_code == CMD_SOFT_RESET |-> soft_reset) else $error("Reset missed");
   a_wr_one_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_valid |=> !wr_valid) else $error("Write strobe longer than one cycle");
   a_wr_prefix_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_valid |-> cmd_code[7:6] == PFX_REG_WRITE && wr.addr == cmd_code[5:0])
      else $error("Write without matching write command");
   a_rd_addr_track: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmd_valid && cmd_code[7:6] == PFX_REG_READ |-> reg_addr == cmd_code[5:0])
      else $error("Read address not taken from command");
endmodule
bind sics_i2c_slave sics_i2c_slave_chk sics_i2c_slave_chk_inst (.core_clk, .reset_n,
   .scl_in, .sda_oe, .reg_addr, .cmd_valid, .cmd_code, .wr_valid, .wr, .soft_reset);

// File: sics_host.sv
// Purpose: Bus host model that bit-bangs the two-wire link
// Assumes: SDA has a pull-up; sda is the resolved wire level
// Notes:   SCL period 32 ns, stands high between frames
`timescale 1ns/1ps
module sics_host (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic start();
      sda_pull = 1'b1;
      #16 scl = 1'b0;
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_pull = ~b;
      #8 scl = 1'b1;
      #8 r = sda;
      #8 scl = 1'b0;
      #8;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      #8 scl = 1'b1;
      #8 sda_pull = 1'b0;
      #1000;
   endtask
endmodule

// File: sics_i2c_slave_test.sv
// Purpose: Self-checking bench for the sensor two-wire target port
// Assumes: Host model drives the link; SDA pulled up
// Notes:   Core-side inputs change at core_clk fall
`timescale 1ns/1ps
module sics_i2c_slave_test;
   import sics_pkg::*;
   logic         core_clk, reset_n, sel, scl, sda_pull, sda_oe, sda_out;
   logic         cmd_valid, wr_valid, soft_reset;
   logic [5:0]   reg_addr;
   logic [7:0]   reg_rdata, cmd_code;
   sics_result_t results;
   sics_reg_wr_t wr, wr_seen;
   int           num_errors, checks, cmd_cnt, wr_cnt, rst_cnt;
   wire          sda = ~sda_pull & (~sda_oe | sda_out);
   sics_i2c_slave sics_i2c_slave_inst (.core_clk, .reset_n, .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe, .address_select_pin(sel), .results, .reg_rdata, .reg_addr,
      .cmd_valid, .cmd_code, .wr_valid, .wr, .soft_reset);
   sics_host sics_host_inst (.scl, .sda_pull, .sda);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      reg_rdata <= {2'b01, reg_addr};
      cmd_cnt += int'(cmd_valid);
      rst_cnt += int'(soft_reset);
      if (wr_valid) begin
         wr_cnt++;
         wr_seen = wr;
      end
   end
   task automatic print_verdict();
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      checks++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic want);
      logic a;
      sics_host_inst.send(b, a);
      check({47'h0, a}, {47'h0, want});
   endtask
   task automatic wait_cmd(input int n);
      for (int i = 0; i < 40 && cmd_cnt != n; i++)
         @(negedge core_clk);
      if (cmd_cnt != n) begin
         num_errors++;
         print_verdict();
      end
   endtask
   task automatic t_addr_miss();
      int n;
      n = cmd_cnt;
      @(negedge core_clk) sel = 1'b1;
      sics_host_inst.start();
      tx(8'hEE, 1'b0);
      sics_host_inst.stop();
      sics_host_inst.start();
      tx(8'h6C, 1'b0);
      tx(8'h06, 1'b0);
      sics_host_inst.stop();
      check(48'(cmd_cnt), 48'(n));
   endtask
   task automatic t_write_reg();
      int n;
      n = cmd_cnt;
      @(negedge core_clk) sel = 1'b0;
      sics_host_inst.start();
      tx(8'hEE, 1'b1);
      tx(8'hC5, 1'b1);
      tx(8'hA7, 1'b1);
      tx(8'h55, 1'b0);
      sics_host_inst.stop();
      wait_cmd(n + 1);
      check({40'h0, cmd_code}, {40'h0, PFX_REG_WRITE, 6'h05});
      check(48'(wr_cnt), 48'h1);
      check({34'h0, wr_seen}, {34'h0, 6'h05, 8'hA7});
   endtask
   task automatic t_soft_reset();
      int n;
      n = cmd_cnt;
      sics_host_inst.start();
      tx(8'hEE, 1'b1);
      tx(8'h06, 1'b1);
      sics_host_inst.stop();
      wait_cmd(n + 1);
      check({40'h0, cmd_code}, {40'h0, CMD_SOFT_RESET});
      check(48'(rst_cnt), 48'h1);
   endtask
   task automatic t_reg_read();
      int n;
      logic [7:0] b;
      n = cmd_cnt;
      @(negedge core_clk) sel = 1'b1;
      sics_host_inst.start();
      tx(8'hEC, 1'b1);
      tx(8'hAA, 1'b1);
      sics_host_inst.stop();
      wait_cmd(n + 1);
      check({42'h0, reg_addr}, {42'h0, 6'h2A});
      sics_host_inst.start();
      tx(8'hED, 1'b1);
      sics_host_inst.recv(1'b1, b);
      sics_host_inst.stop();
      check({40'h0, b}, {40'h0, 8'h6A});
   endtask
   task automatic t_results();
      int n;
      logic [7:0] b;
      logic [7:0] cmds [5];
      logic [47:0] want [5];
      logic [47:0] got;
      cmds = '{8'h10, 8'h11, 8'h30, 8'h31, 8'h32};
      want = '{{results.temp, results.press}, {results.temp, results.alt},
         {24'h0, results.press}, {24'h0, results.alt}, {24'h0, results.temp}};
      for (int k = 0; k < 5; k++) begin
         @(negedge core_clk) sel = k[0];
         n = cmd_cnt;
         sics_host_inst.start();
         tx(k[0] ? 8'hEC : 8'hEE, 1'b1);
         tx(cmds[k], 1'b1);
         sics_host_inst.stop();
         wait_cmd(n + 1);
         sics_host_inst.start();
         tx(k[0] ? 8'hED : 8'hEF, 1'b1);
         got = '0;
         for (int i = 0; i < (k < 2 ? 6 : 3); i++) begin
            sics_host_inst.recv(i == (k < 2 ? 5 : 2), b);
            got = {got[39:0], b};
         end
         sics_host_inst.stop();
         check(got, want[k]);
      end
   endtask
   initial begin
      reset_n = 1'b1;
      sel = 1'b0;
      reg_rdata = 8'h00;
      results = {24'h12_3456, 24'h89_ABCD, 24'hFE_DC21};
      #1 reset_n = 1'b0;
      repeat (5) @(negedge core_clk);
      reset_n = 1'b1;
      t_addr_miss();
      t_write_reg();
      t_soft_reset();
      t_reg_read();
      t_results();
      print_verdict();
   end
endmodule
